// ---- rtl/pasi_pkg.sv ----
// Package of constants and types for the pipelined sample interface
// Functional notes
// - Each rising conversion clock edge starts one simultaneous differential sample
// - Result appears two starts plus conversion later
// - New conversion every rising edge, one result per conversion clock cycle
// - Idle timer refreshes dynamic logic after 1ms
// - Result is 12-bit two's complement plus flag
// - Gain strap high selects 1x, low 2x
// - Reference strap selects 4.096V, 2.048V or external
// - Flag high exactly at extreme codes
package pasi_pkg;
    localparam int RESULT_WIDTH = 12;
    localparam int PIPE_DEPTH = 2;
    localparam int CLK_PERIOD_NS = 10;
    localparam int CONV_TIME_NS = 150;
    localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int IDLE_TIME_MS = 1;
    localparam int IDLE_CYCLES_DEF = IDLE_TIME_MS * 1000000 / CLK_PERIOD_NS;
    localparam int MIN_RATE_KHZ = 20;
    localparam logic [RESULT_WIDTH-1:0] CODE_MAX_POS = 12'h7ff;
    localparam logic [RESULT_WIDTH-1:0] CODE_MAX_NEG = 12'h800;
    localparam logic [RESULT_WIDTH-1:0] RESULT_RST = 12'h000;
    // Reference span selection from the strap
    typedef enum logic [1:0] {
        PASI_REF_4V096,
        PASI_REF_2V048,
        PASI_REF_EXTERNAL
    } pasi_ref_type;
    typedef enum logic {
        PASI_GAIN_2X,
        PASI_GAIN_1X
    } pasi_gain_type;
endpackage

// ---- rtl/pasi_stage_if.sv ----
// Interface carrying one pipeline stage's sample word and flag
`timescale 1ns/10ps
`default_nettype none
interface pasi_stage_if;
    import pasi_pkg::*;
    logic load;
    logic [RESULT_WIDTH-1:0] code;
    logic [RESULT_WIDTH-1:0] held_code;
    logic held_flag;
    modport src (output load, output code, input held_code, input held_flag);
    modport dst (input load, input code, output held_code, output held_flag);
endinterface
`default_nettype wire

// ---- rtl/pasi_out_stage.sv ----
// Output register holding the result word and out-of-range flag
`timescale 1ns/10ps
`default_nettype none
module pasi_out_stage
    import pasi_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    pasi_stage_if.dst stage
);
    logic [RESULT_WIDTH-1:0] code_q;
    logic flag_q;
    wire logic extreme_w;
    // Flag decode on the extreme codes
    assign extreme_w = (stage.code == CODE_MAX_POS) || (stage.code == CODE_MAX_NEG);
    // Update only on load, hold otherwise
    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
        begin
            code_q <= RESULT_RST;
            flag_q <= 1'b0;
        end
        else if (stage.load)
        begin
            code_q <= stage.code;
            flag_q <= extreme_w;
        end
    end
    assign stage.held_code = code_q;
    assign stage.held_flag = flag_q;
endmodule // pasi_out_stage
`default_nettype wire

// ---- rtl/pasi_top.sv ----
// Digital side of the pipelined sample converter
`timescale 1ns/10ps
`default_nettype none
module pasi_top
    import pasi_pkg::*;
#(
    parameter int IDLE_CYCLES = IDLE_CYCLES_DEF
)
(
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic conv_clk_in,
    input wire logic [RESULT_WIDTH-1:0] sample_code_in,
    input wire logic gain_strap_in,
    input wire logic [1:0] ref_strap_in,
    output logic [RESULT_WIDTH-1:0] result_word_bits_out,
    output logic out_of_range_flag_out,
    output logic result_update_out,
    output logic gain_is_1x_out,
    output logic [1:0] ref_select_out,
    output logic ref_amp_enable_out,
    output logic refresh_active_out
);
    localparam int PIPE_CW = 8;
    localparam int IDLE_CW = 32;
    logic conv_clk_q;
    wire logic start_w;
    logic [RESULT_WIDTH-1:0] pipe_code_q [PIPE_DEPTH];
    logic [PIPE_DEPTH-1:0] pipe_valid_q;
    logic conv_busy_q;
    logic [PIPE_CW-1:0] conv_cnt_q;
    logic [RESULT_WIDTH-1:0] conv_code_q;
    logic update_q;
    logic [IDLE_CW-1:0] idle_cnt_q;
    logic refresh_q;
    logic gain_q;
    logic [1:0] ref_q;
    logic amp_en_q;
    wire logic conv_done_w;
    wire logic idle_hit_w;
    wire pasi_ref_type ref_sel_w;
    pasi_stage_if stage_bus ();
    // Rising edge of the conversion clock starts a conversion
    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
            conv_clk_q <= 1'b0;
        else
            conv_clk_q <= conv_clk_in;
    end
    assign start_w = conv_clk_in && !conv_clk_q;
    // Sample shift pipeline, one entry per start
    generate
        for (genvar i = 0; i < PIPE_DEPTH; i++)
        begin : g_pipe
            always_ff @(posedge sys_clk_in)
            begin
                if (!rst_n_in)
                begin
                    pipe_code_q[i] <= RESULT_RST;
                    pipe_valid_q[i] <= 1'b0;
                end
                else if (start_w)
                begin
                    if (i == 0)
                    begin
                        pipe_code_q[i] <= sample_code_in;
                        pipe_valid_q[i] <= 1'b1;
                    end
                    else
                    begin
                        pipe_code_q[i] <= pipe_code_q[i-1];
                        pipe_valid_q[i] <= pipe_valid_q[i-1];
                    end
                end
            end
        end
    endgenerate
    // Conversion timer: last stage result emerges after conversion time
    assign conv_done_w = conv_busy_q && (conv_cnt_q == PIPE_CW'(CONV_CYCLES - 1));
    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
        begin
            conv_busy_q <= 1'b0;
            conv_cnt_q <= '0;
            conv_code_q <= RESULT_RST;
        end
        else if (start_w && pipe_valid_q[PIPE_DEPTH-1])
        begin
            conv_busy_q <= 1'b1;
            conv_cnt_q <= '0;
            conv_code_q <= pipe_code_q[PIPE_DEPTH-1];
        end
        else if (conv_done_w)
            conv_busy_q <= 1'b0;
        else if (conv_busy_q)
            conv_cnt_q <= conv_cnt_q + PIPE_CW'(1);
    end
    // Output stage loads at end of conversion
    assign stage_bus.load = conv_done_w;
    assign stage_bus.code = conv_code_q;
    pasi_out_stage u_out (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .stage(stage_bus)
    );
    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
            update_q <= 1'b0;
        else
            update_q <= conv_done_w;
    end
    assign result_word_bits_out = stage_bus.held_code;
    assign out_of_range_flag_out = stage_bus.held_flag;
    assign result_update_out = update_q;
    // Idle timer: refresh dynamic logic when no start for the idle time
    assign idle_hit_w = (idle_cnt_q >= IDLE_CW'(IDLE_CYCLES - 1));
    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
        begin
            idle_cnt_q <= '0;
            refresh_q <= 1'b0;
        end
        else if (start_w)
        begin
            idle_cnt_q <= '0;
            refresh_q <= 1'b0;
        end
        else if (idle_hit_w)
        begin
            idle_cnt_q <= '0;
            refresh_q <= 1'b1;
        end
        else
        begin
            idle_cnt_q <= idle_cnt_q + IDLE_CW'(1);
            refresh_q <= 1'b0;
        end
    end
    assign refresh_active_out = refresh_q;
    // Strap decode for gain and reference span
    assign ref_sel_w = (ref_strap_in == 2'h0) ? PASI_REF_4V096 :
                       (ref_strap_in == 2'h1) ? PASI_REF_2V048 : PASI_REF_EXTERNAL;
    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
        begin
            gain_q <= 1'b1;
            ref_q <= 2'h0;
            amp_en_q <= 1'b1;
        end
        else
        begin
            gain_q <= (gain_strap_in ? PASI_GAIN_1X : PASI_GAIN_2X) == PASI_GAIN_1X;
            ref_q <= ref_sel_w;
            amp_en_q <= (ref_sel_w != PASI_REF_EXTERNAL);
        end
    end
    assign gain_is_1x_out = gain_q;
    assign ref_select_out = ref_q;
    assign ref_amp_enable_out = amp_en_q;
endmodule // pasi_top
`default_nettype wire

// ---- testbench/pasi_chk.sv ----
// Port checker for the pipelined sample interface
`timescale 1ns/10ps
`default_nettype none
module pasi_chk
    import pasi_pkg::*;
#(parameter int IDLE_CYCLES = 50)
(
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic conv_clk_in,
    input wire logic gain_strap_in,
    input wire logic [1:0] ref_strap_in,
    input wire logic [RESULT_WIDTH-1:0] result_word_bits_out,
    input wire logic out_of_range_flag_out,
    input wire logic result_update_out,
    input wire logic gain_is_1x_out,
    input wire logic [1:0] ref_select_out,
    input wire logic ref_amp_enable_out,
    input wire logic refresh_active_out
);
    logic conv_q;
    logic [31:0] idle_q;
    wire logic start = conv_clk_in && !conv_q;
    wire logic [11:0] res = result_word_bits_out;
    // Start edge and cycles since the last start
    always_ff @(posedge sys_clk_in)
    begin
        conv_q <= rst_n_in && conv_clk_in;
        idle_q <= (!rst_n_in || start) ? 32'h0 : idle_q + 32'h1;
    end
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence settled;
        $past(rst_n_in) && $past(rst_n_in, 2);
    endsequence
    sequence loaded;
        $past(start, 16) || $past(start, 17);
    endsequence
    flag_match_a: assert property (
        out_of_range_flag_out == (res == 12'h7ff || res == 12'h800)) else $error("flag");
    gain_map_a: assert property (
        settled |-> gain_is_1x_out == $past(gain_strap_in)) else $error("gain");
    ref_map_a: assert property (
        settled |-> ref_select_out == ($past(ref_strap_in) > 2'h1 ? 2'h2 : $past(ref_strap_in)))
        else $error("ref");
    amp_enable_a: assert property (
        settled |-> ref_amp_enable_out == ($past(ref_strap_in) < 2'h2)) else $error("amp");
    update_latency_a: assert property (
        result_update_out |-> loaded) else $error("latency");
    change_pulse_a: assert property (
        $changed(res) |-> result_update_out) else $error("change");
    pulse_single_a: assert property (
        result_update_out |=> !result_update_out) else $error("pulse");
    refresh_idle_a: assert property (
        refresh_active_out |-> idle_q >= IDLE_CYCLES - 2) else $error("refresh");
endmodule // pasi_chk
bind pasi_top pasi_chk #(.IDLE_CYCLES(IDLE_CYCLES)) chk (.*);
`default_nettype wire

// ---- testbench/pasi_host_model.sv ----
// Capturing host that clocks conversions and latches results
`timescale 1ns/10ps
`default_nettype none
module pasi_host_model
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic run_in,
    input wire logic [11:0] next_in,
    input wire logic [11:0] result_in,
    output logic conv_out,
    output logic [11:0] code_out,
    output logic [11:0] latched_out,
    output logic edge_out
);
    logic [4:0] ph_q;
    wire logic go = rst_n_in && run_in;
    // 20-cycle clock, idle low when stopped; code toggles outside its hold
    always_ff @(posedge clk_in)
    begin
        ph_q <= (!go || ph_q == 5'h13) ? 5'h0 : ph_q + 5'h1;
        conv_out <= go && ph_q < 5'ha;
        edge_out <= go && ph_q == 5'h0;
        code_out <= !rst_n_in ? 12'h5a5 : (go && ph_q == 5'h0) ? next_in : ~code_out;
        if (go && ph_q == 5'h0)
            latched_out <= result_in;
    end
endmodule // pasi_host_model
`default_nettype wire

// ---- testbench/tb.sv ----
// Self-checking bench for the pipelined sample interface
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic sys_clk_in = 1'b0, rst_n_in = 1'b0, gain_strap_in = 1'b1, run = 1'b0, host_edge;
    logic conv_clk_in, out_of_range_flag_out, result_update_out, gain_is_1x_out;
    logic ref_amp_enable_out, refresh_active_out;
    logic [1:0] ref_strap_in = 2'h0, ref_select_out;
    logic [11:0] nxt = 12'h7ff, sample_code_in, result_word_bits_out, latched;
    logic [11:0] codes [8] = '{12'h7ff, 12'h800, 12'h0, 12'h123, 12'h7fe, 12'h801, 12'hfff, 12'h7ff};
    int error_cnt = 0, compares = 0;
    // 100 MHz clock
    always #5 sys_clk_in = ~sys_clk_in;
    pasi_top #(.IDLE_CYCLES(50)) dut (.*);
    pasi_host_model host (.clk_in(sys_clk_in), .rst_n_in(rst_n_in), .run_in(run),
        .next_in(nxt), .result_in(result_word_bits_out), .conv_out(conv_clk_in),
        .code_out(sample_code_in), .latched_out(latched), .edge_out(host_edge));
    // Compare and count
    task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
        compares++;
        if (seen !== exp)
        begin
            $display("wrong value %s expected %h seen %h", name, exp, seen);
            error_cnt++;
        end
    endtask
    // Counts, verdict, stop
    task automatic summarize();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Bounded wait for a pulse
    task automatic wait_high(ref logic sig);
        for (int i = 0; i < 100 && sig !== 1'b1; i++)
            @(posedge sys_clk_in);
        check("pulse", {11'h0, sig}, 12'h1);
        if (sig !== 1'b1)
            summarize();
    endtask
    // All strap settings
    task automatic test_straps();
        for (int k = 0; k < 8; k++)
        begin
            gain_strap_in <= k[0];
            ref_strap_in <= k[2:1];
            repeat (3) @(posedge sys_clk_in);
            check("gain", {11'h0, gain_is_1x_out}, {11'h0, k[0]});
            check("ref", {10'h0, ref_select_out}, (k > 3) ? 12'h2 : {10'h0, k[2:1]});
            check("amp", {11'h0, ref_amp_enable_out}, {11'h0, k < 4});
        end
        $display("straps done");
    endtask
    // Back-to-back conversions with extreme codes
    task automatic test_stream();
        logic [11:0] c;
        logic f;
        run <= 1'b1;
        for (int j = 0; j < 11; j++)
        begin
            wait_high(host_edge);
            nxt <= codes[(j + 1) % 8];
            c = codes[(j + 5) % 8];
            f = c == 12'h7ff || c == 12'h800;
            if (j == 2)
                check("early", result_word_bits_out, 12'h0);
            if (j > 2)
            begin
                check("result", result_word_bits_out, c);
                check("latched", latched, c);
                check("flag", {11'h0, out_of_range_flag_out}, {11'h0, f});
                check("update", {11'h0, result_update_out}, 12'h0);
            end
            @(posedge sys_clk_in);
        end
        $display("stream done");
    endtask
    // Refresh while the clock stands still
    task automatic test_idle();
        run <= 1'b0;
        @(posedge sys_clk_in);
        check("idle", {11'h0, refresh_active_out}, 12'h0);
        wait_high(refresh_active_out);
        @(posedge sys_clk_in);
        wait_high(refresh_active_out);
        $display("idle done");
    endtask
    // Main sequence
    initial
    begin
        repeat (6) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        @(posedge sys_clk_in);
        test_straps();
        test_stream();
        test_idle();
        summarize();
    end
endmodule // tb
`default_nettype wire
